// File: pkg/nic_pm_perf_regs.svh
// Function
// - forced wake bit drives wake output directly
// - pattern pointer reset bit restarts pattern pointer
// - pause bit defaults from autonegotiation, software overrides
// - threshold disabled means fixed 64 bytes
// - threshold field 32, 64, store-forward, reserved
// - bit 0 enables underrun auto recovery
// - clock field accumulates read latency clocks
// - dword field accumulates bus master dwords
// - counter fields read only, cleared by read
// - event status sets on wake regardless enable
// - writing one clears event status
// - event status resets to zero
// - data scale and select read zero
// - event enable gates wake latch, not forced wake, default zero
// - power state field reports and accepts state
// - unsupported power state write is discarded
// - config mirror shows same register value
// - reset-clear option returns state to D0
// - sticky option holds wake through power up
`ifndef NIC_PM_PERF_REGS_SVH
`define NIC_PM_PERF_REGS_SVH
`define OFS_MISC_CONFIG 8'h88
`define OFS_PERF_COUNTER 8'h8c
`define OFS_PM_CTRL_STATUS 8'h90
`define OFS_PM_OPTIONS 8'h84
`define BIT_FORCED_WAKE 7
`define BIT_PTR_RESET 6
`define BIT_PAUSE 5
`define BIT_THR_EN 4
`define FLD_DRAIN_HI 3
`define FLD_DRAIN_LO 2
`define BIT_SOFT_IRQ 1
`define BIT_UNDERRUN 0
`define FLD_CLK_HI 31
`define FLD_CLK_LO 16
`define FLD_DW_HI 7
`define FLD_DW_LO 0
`define BIT_EVT_STATUS 15
`define BIT_EVT_ENABLE 8
`define FLD_PWR_HI 1
`define FLD_PWR_LO 0
`define BIT_OPT_RESET_CLR 1
`define BIT_OPT_STICKY 0
`define MISC_RESET 8'h00
`define PWR_SUPPORTED 4'b1111
`endif

// File: pkg/nic_pm_perf_pkg.sv
package nic_pm_perf_pkg;
  typedef enum logic [1:0] {
    DRAIN_32 = 2'b00, DRAIN_64 = 2'b01, DRAIN_SF = 2'b10, DRAIN_RSV = 2'b11
  } drain_t;
  typedef enum logic [1:0] {
    PWR_D0 = 2'b00, PWR_D1 = 2'b01, PWR_D2 = 2'b10, PWR_D3HOT = 2'b11
  } power_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic pause_en;
    drain_t drain;
    logic underrun_recover;
    logic ptr_reset;
    logic soft_irq;
  } misc_ctrl_t;
endpackage

// File: rtl/nic_pm_perf_config_regs.sv
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "nic_pm_perf_regs.svh"
module nic_pm_perf_config_regs
  import nic_pm_perf_pkg::*;
#(
  parameter int CLK_W = 16,
  parameter int DW_W = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clock_en,
  // register port
  input wire reg_req_t i_req,
  output logic [31:0] o_rdata,
  // configuration space mirror port
  input wire logic i_cfg_wr,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_pmcsr,
  // events from the mac
  input wire logic i_autoneg_done,
  input wire logic i_autoneg_pause,
  input wire logic i_wake_event,
  input wire logic i_power_up,
  input wire logic i_bus_reset_rise,
  input wire logic i_read_busy,
  input wire logic i_master_dword,
  // controls to the mac
  output misc_ctrl_t o_misc,
  output logic o_wake_n,
  output logic o_irq
);
  // the read word packs both counters at fixed positions
  if (CLK_W != 16 || DW_W != 8) begin : g_bad_width
    $error("counter widths fixed by layout");
  end

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] misc_reg;
  logic [CLK_W-1:0] clk_cnt_reg;
  logic [DW_W-1:0] dw_cnt_reg;
  logic evt_status_reg;
  logic evt_enable_reg;
  power_state_t pwr_reg;
  logic [1:0] opt_reg;
  logic wake_latch_reg;

  logic wr_misc, wr_pm, rd_perf, pm_wr_any;
  logic [31:0] pm_wdata, pm_view;
  assign wr_misc = i_req.wr && i_req.addr == `OFS_MISC_CONFIG;
  assign wr_pm = i_req.wr && i_req.addr == `OFS_PM_CTRL_STATUS;
  assign rd_perf = i_req.rd && i_req.addr == `OFS_PERF_COUNTER;
  // register port wins if both views write in the same cycle
  assign pm_wr_any = wr_pm || i_cfg_wr;
  assign pm_wdata = wr_pm ? i_req.wdata : i_cfg_wdata;

  // data scale / select read zero, no power data register
  always_comb begin
    pm_view = '0;
    pm_view[`BIT_EVT_STATUS] = evt_status_reg;
    pm_view[`BIT_EVT_ENABLE] = evt_enable_reg;
    pm_view[`FLD_PWR_HI:`FLD_PWR_LO] = pwr_reg;
  end

  // ------------------------------------------------------------
  // miscellaneous configuration
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      misc_reg <= `MISC_RESET;
    end else if (i_clock_en) begin
      if (wr_misc) begin
        misc_reg <= i_req.wdata[7:0];
      end else if (i_autoneg_done) begin
        misc_reg[`BIT_PAUSE] <= i_autoneg_pause;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      opt_reg <= 2'b00;
    end else if (i_clock_en && i_req.wr && i_req.addr == `OFS_PM_OPTIONS) begin
      opt_reg <= i_req.wdata[1:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_misc <= '0;
      o_irq <= 1'b0;
    end else if (i_clock_en) begin
      o_misc.pause_en <= misc_reg[`BIT_PAUSE];
      o_misc.underrun_recover <= misc_reg[`BIT_UNDERRUN];
      o_misc.ptr_reset <= misc_reg[`BIT_PTR_RESET];
      o_misc.soft_irq <= misc_reg[`BIT_SOFT_IRQ];
      o_irq <= misc_reg[`BIT_SOFT_IRQ];
      if (!misc_reg[`BIT_THR_EN]) begin
        o_misc.drain <= DRAIN_64;
      end else begin
        o_misc.drain <= drain_t'(misc_reg[`FLD_DRAIN_HI:`FLD_DRAIN_LO]);
      end
    end
  end

  // ------------------------------------------------------------
  // performance counters
  // ------------------------------------------------------------
  // saturate rather than wrap, so a long gap between reads reads large
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      clk_cnt_reg <= '0;
    end else if (i_clock_en) begin
      if (rd_perf) begin
        clk_cnt_reg <= '0;
      end else if (i_read_busy && ~&clk_cnt_reg) begin
        clk_cnt_reg <= clk_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      dw_cnt_reg <= '0;
    end else if (i_clock_en) begin
      if (rd_perf) begin
        dw_cnt_reg <= '0;
      end else if (i_master_dword && ~&dw_cnt_reg) begin
        dw_cnt_reg <= dw_cnt_reg + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // power management command / status
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      evt_status_reg <= 1'b0;
    end else if (i_clock_en) begin
      if (i_wake_event) begin
        evt_status_reg <= 1'b1;
      end else if (pm_wr_any && pm_wdata[`BIT_EVT_STATUS]) begin
        evt_status_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      evt_enable_reg <= 1'b0;
    end else if (i_clock_en && pm_wr_any) begin
      evt_enable_reg <= pm_wdata[`BIT_EVT_ENABLE];
    end
  end

  logic [3:0] pwr_ok;
  assign pwr_ok = `PWR_SUPPORTED;
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pwr_reg <= PWR_D0;
    end else if (i_clock_en) begin
      if (i_bus_reset_rise && opt_reg[`BIT_OPT_RESET_CLR]) begin
        pwr_reg <= PWR_D0;
      end else if (pm_wr_any && pwr_ok[pm_wdata[`FLD_PWR_HI:`FLD_PWR_LO]]) begin
        pwr_reg <= power_state_t'(pm_wdata[`FLD_PWR_HI:`FLD_PWR_LO]);
      end
    end
  end

  // wake latch: an enabled wake event asserts, power up releases unless sticky
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      wake_latch_reg <= 1'b0;
    end else if (i_clock_en) begin
      if (i_wake_event && evt_enable_reg) begin
        wake_latch_reg <= 1'b1;
      end else if (pm_wr_any && pm_wdata[`BIT_EVT_STATUS]) begin
        wake_latch_reg <= 1'b0;
      end else if (i_power_up && !opt_reg[`BIT_OPT_STICKY]) begin
        wake_latch_reg <= 1'b0;
      end else if (!evt_enable_reg) begin
        wake_latch_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_wake_n <= 1'b1;
      o_cfg_pmcsr <= '0;
    end else if (i_clock_en) begin
      o_wake_n <= !(misc_reg[`BIT_FORCED_WAKE] || wake_latch_reg);
      o_cfg_pmcsr <= pm_view;
    end
  end

  // ------------------------------------------------------------
  // read data, one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_clock_en) begin
      o_rdata <= '0;
      if (i_req.rd) begin
        unique case (i_req.addr)
          `OFS_MISC_CONFIG: o_rdata <= {24'h00_0000, misc_reg};
          `OFS_PERF_COUNTER: o_rdata <= {clk_cnt_reg, 8'h00, dw_cnt_reg};
          `OFS_PM_CTRL_STATUS: o_rdata <= pm_view;
          `OFS_PM_OPTIONS: o_rdata <= {30'h0000_0000, opt_reg};
          default: o_rdata <= '0;
        endcase
      end
    end
  end
endmodule // nic_pm_perf_config_regs

// File: verification/nic_pm_perf_assertions.sv
`timescale 1ns/100ps
`include "nic_pm_perf_regs.svh"
module nic_pm_perf_checker
  import nic_pm_perf_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // register port
  input wire reg_req_t i_req,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] o_cfg_pmcsr,
  // controls
  input wire misc_ctrl_t o_misc,
  input wire logic o_wake_n,
  input wire logic o_irq
);
  // ----
  // checks
  // ----
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  wire mw = i_req.wr && i_req.addr == `OFS_MISC_CONFIG;
  wire pr = i_req.rd && i_req.addr == `OFS_PERF_COUNTER;
  wire qr = i_req.rd && i_req.addr == `OFS_PM_CTRL_STATUS;
  chk_force_wake: assert property (
    mw && i_req.wdata[7] |-> ##2 !o_wake_n) else $error("wake not driven");
  chk_drain_sel: assert property (
    mw && i_req.wdata[3:2] != 2'b11 |-> ##2 o_misc.drain ==
    ($past(i_req.wdata[4], 2) ? $past(i_req.wdata[3:2], 2) : DRAIN_64))
    else $error("drain threshold wrong");
  chk_underrun_bit: assert property (
    mw |-> ##2 o_misc.underrun_recover == $past(i_req.wdata[0], 2)) else $error("underrun bad");
  chk_soft_irq: assert property (
    mw |-> ##2 o_irq == $past(i_req.wdata[1], 2)) else $error("irq bad");
  chk_perf_rsvd: assert property (
    $past(pr) |-> o_rdata[15:8] == 8'h00) else $error("counter reserved bits set");
  chk_pm_rsvd: assert property (
    $past(qr) |-> (o_rdata & 32'hffff_7efc) == 32'h0000_0000) else $error("pm reserved set");
  chk_mirror_same: assert property (
    $past(qr) |-> o_rdata == o_cfg_pmcsr) else $error("mirror differs");
  chk_status_reset: assert property (
    $rose(i_resetn) |-> o_cfg_pmcsr == 32'h0000_0000) else $error("pm not cleared");
  cover property (mw ##2 !o_wake_n);
  cover property (pr);
  cover property (qr ##1 o_rdata[15]);
endmodule // nic_pm_perf_checker
bind nic_pm_perf_config_regs nic_pm_perf_checker nic_pm_perf_checker_inst (.i_clock(i_clock),
  .i_resetn(i_resetn), .i_req(i_req), .o_rdata(o_rdata), .o_cfg_pmcsr(o_cfg_pmcsr),
  .o_misc(o_misc), .o_wake_n(o_wake_n), .o_irq(o_irq));

// File: verification/nic_mac_model.sv
`timescale 1ns/100ps
module nic_mac_model (
  // clock
  input wire logic i_clock,
  // burst request
  input wire logic i_go,
  input wire logic [7:0] i_len,
  // activity toward the bank
  output logic o_read_busy,
  output logic o_master_dword
);
  // ----
  // burst length countdown
  // ----
  logic [7:0] left_reg = 8'h00;
  always_ff @(posedge i_clock) begin
    if (i_go) begin
      left_reg <= i_len;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  // one dword per busy cycle keeps both counts equal until the dword count saturates at 255
  assign o_read_busy = left_reg != 8'h00;
  assign o_master_dword = left_reg != 8'h00;
endmodule // nic_mac_model

// File: verification/tb.sv
`timescale 1ns/100ps
module tb;
  import nic_pm_perf_pkg::*;
  logic i_clock = 0;
  logic i_resetn = 0;
  reg_req_t req = '0;
  logic cfg_wr = 0;
  logic [31:0] cfg_wdata = '0;
  logic [2:0] ev = '0;
  logic pu = 0;
  logic go = 0;
  logic [7:0] len = '0;
  logic busy, dword, wake_n, irq;
  logic [31:0] rdata, pmcsr;
  misc_ctrl_t misc;
  logic [31:0] vals [4] = '{32'h0000_0053, 32'h0000_0014, 32'h0000_0018, 32'h0000_0008};
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  // ----
  // clock and instances
  // ----
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  nic_mac_model nic_mac_model_inst (.i_clock(i_clock), .i_go(go), .i_len(len),
    .o_read_busy(busy), .o_master_dword(dword));
  nic_pm_perf_config_regs nic_pm_perf_config_regs_inst (.i_clock(i_clock),
    .i_resetn(i_resetn), .i_clock_en(1'b1), .i_req(req), .o_rdata(rdata), .i_cfg_wr(cfg_wr),
    .i_cfg_wdata(cfg_wdata), .o_cfg_pmcsr(pmcsr), .i_autoneg_done(ev[1]),
    .i_autoneg_pause(1'b1), .i_wake_event(ev[2]), .i_power_up(pu), .i_bus_reset_rise(ev[0]),
    .i_read_busy(busy), .i_master_dword(dword), .o_misc(misc), .o_wake_n(wake_n), .o_irq(irq));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock) req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clock) req.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clock) req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge i_clock) req.rd <= 1'b0;
    @(negedge i_clock) chk("rdata", e, rdata);
  endtask
  task pulse(input logic [2:0] p);
    @(posedge i_clock) ev <= p;
    @(posedge i_clock) ev <= 3'h0;
  endtask
  task finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // hang guard and tests
  // ----
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    rd(8'h8c, 32'h0000_0000);
    rd(8'h90, 32'h0000_0000);
    rd(8'hfc, 32'h0000_0000);
    $display("reset test done");
    foreach (vals[i]) begin
      wr(8'h88, vals[i]);
      rd(8'h88, vals[i]);
      chk("drain", vals[i][4] ? vals[i][3:2] : 2'b01, misc.drain);
      chk("underrun", vals[i][0], misc.underrun_recover);
      chk("irq", vals[i][1], irq);
      chk("soft", vals[i][1], misc.soft_irq);
      chk("ptr", vals[i][6], misc.ptr_reset);
    end
    pulse(3'b010);
    rd(8'h88, 32'h0000_0028);
    chk("pause", 1, misc.pause_en);
    wr(8'h88, 32'h0000_0080);
    rd(8'h88, 32'h0000_0080);
    chk("wake_n", 0, wake_n);
    wr(8'h88, 32'h0000_0000);
    rd(8'h88, 32'h0000_0000);
    chk("wake_n", 1, wake_n);
    $display("misc test done");
    @(posedge i_clock) go <= 1'b1;
    len <= 8'd5;
    @(posedge i_clock) go <= 1'b0;
    repeat (8) @(posedge i_clock);
    rd(8'h8c, 32'h0005_0005);
    rd(8'h8c, 32'h0000_0000);
    $display("counter test done");
    wr(8'h90, 32'h0000_0103);
    pulse(3'b100);
    rd(8'h90, 32'h0000_8103);
    chk("wake_n", 0, wake_n);
    wr(8'h90, 32'h0000_8103);
    rd(8'h90, 32'h0000_0103);
    chk("wake_n", 1, wake_n);
    wr(8'h90, 32'h0000_0000);
    pulse(3'b100);
    rd(8'h90, 32'h0000_8000);
    chk("wake_n", 1, wake_n);
    @(posedge i_clock) cfg_wr <= 1'b1;
    cfg_wdata <= 32'h0000_8002;
    @(posedge i_clock) cfg_wr <= 1'b0;
    rd(8'h90, 32'h0000_0002);
    chk("mirror", 32'h0000_0002, pmcsr);
    wr(8'h90, 32'h0000_7e01);
    rd(8'h90, 32'h0000_0001);
    wr(8'h84, 32'h0000_0002);
    pulse(3'b001);
    rd(8'h90, 32'h0000_0000);
    wr(8'h90, 32'h0000_0100);
    pulse(3'b100);
    @(posedge i_clock) pu <= 1'b1;
    @(posedge i_clock) pu <= 1'b0;
    rd(8'h90, 32'h0000_8100);
    chk("wake_n", 1, wake_n);
    wr(8'h84, 32'h0000_0001);
    wr(8'h90, 32'h0000_8100);
    pulse(3'b100);
    @(posedge i_clock) pu <= 1'b1;
    @(posedge i_clock) pu <= 1'b0;
    rd(8'h90, 32'h0000_8100);
    chk("wake_n", 0, wake_n);
    $display("power test done");
    finish_test();
  end
endmodule // tb
